// ===== logic/load_threshold_map.svh
// Constants for the load threshold monitor
`ifndef LOAD_THRESHOLD_MAP_SVH
`define LOAD_THRESHOLD_MAP_SVH

`define MODE_LOW_POWER        1'b0
`define MODE_HIGH_POWER       1'b1
`define LOW_THRESH_RESET      7'h00
`define HIGH_THRESH_RESET     7'h00
`define PERCENT_FULL_SCALE    7'h64
`define CLOCK_HZ              100000000
`define TICK_PERIOD_S         1
`define TICK_CYCLES           (`CLOCK_HZ * `TICK_PERIOD_S)

`endif

// ===== logic/load_threshold_pkg.sv
// Types shared by the load threshold monitor
package load_threshold_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_WATCH  = 2'b10
  } monitor_state_e;

  typedef struct packed {
    logic        high_mode;
    logic [6:0]  low_percent;
    logic [15:0] low_delay_s;
    logic [6:0]  high_percent;
    logic [15:0] high_delay_s;
    logic [15:0] settle_s;
    logic        enable_input_assigned;
    logic        output_assigned;
  } monitor_cfg_s;

endpackage

// ===== logic/qualify_timer.sv
// Seconds-based qualification timer that restarts when its condition drops
`timescale 1ns/100ps
module qualify_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Timing
  input  wire logic             sec_tick,
  input  wire logic             condition,
  input  wire logic [WIDTH-1:0] delay_s,
  // Result
  output logic                  expired
);

  initial begin
    if (WIDTH < 2) begin
      $error("qualify_timer WIDTH too small");
    end
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  wire              reached = (count_r >= delay_s);
  wire              bump    = sec_tick && !reached;

  // A dropped condition restarts the count
  assign count_nxt = !condition ? '0 :
                     bump       ? count_r + WIDTH'(1) : count_r;
  assign expired   = condition && reached;

  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// ===== logic/load_threshold_monitor.sv
// Load threshold monitor: low or high active power alarm with hysteresis
`timescale 1ns/100ps
`include "load_threshold_map.svh"

// Summary of operation
// [RULE_01] Mode input zero monitors low power, one monitors high power.
// [RULE_02] Reset defaults: low mode, lower threshold zero, so function off.
// [RULE_03] With an assigned enable input, monitor only while it is active.
// [RULE_04] No monitoring unless the load threshold output is assigned.
// [RULE_05] Total delivered power compared with two thresholds forming a band.
// [RULE_06] Low mode: assert after power below lower threshold for its delay.
// [RULE_07] Low mode: deassert after power above upper threshold for its delay.
// [RULE_08] Thresholds are percent of rated power; delays are whole seconds.
// [RULE_09] Both thresholds zero or inconsistent disables the function.
// [RULE_10] Enable activation starts a settle timer holding the output low.
// [RULE_11] High mode: assert above upper, deassert below lower, each delayed.
// [RULE_12] Thresholds inconsistent unless lower is strictly below upper.
// [RULE_13] A qualification delay restarts when its condition drops early.
module load_threshold_monitor
  import load_threshold_pkg::*;
#(
  parameter int POWER_WIDTH = 24,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Configuration
  input  wire monitor_cfg_s           cfg,
  input  wire logic                   cfg_valid,
  input  wire logic [POWER_WIDTH-1:0] rated_power,
  // Measurement and enable
  input  wire logic [POWER_WIDTH-1:0] active_power,
  input  wire logic                   threshold_enable_input,
  // Result
  output logic                        load_threshold_output,
  output logic                        monitor_active
);

  initial begin
    if (POWER_WIDTH < 8 || POWER_WIDTH > 48 || TICK_CYCLES < 1) begin
      $error("load_threshold_monitor parameters out of range");
    end
  end

  localparam int PW = POWER_WIDTH + 8;

  // ************************************************************
  // Configuration hold
  // ************************************************************
  monitor_cfg_s cfg_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_r <= '{high_mode: `MODE_LOW_POWER,
                 low_percent: `LOW_THRESH_RESET,
                 high_percent: `HIGH_THRESH_RESET,
                 default: '0}; // see [RULE_02]
    end else if (cfg_valid) begin
      cfg_r <= cfg;
    end
  end

  // ************************************************************
  // Seconds tick divider
  // ************************************************************
  logic [31:0] div_r;
  wire         sec_tick = (div_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (reset || sec_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 32'h1;
    end
  end

  // ************************************************************
  // Threshold comparison
  // ************************************************************
  // Compare power*100 against rated*percent to avoid a divider
  wire [PW-1:0] power_scaled = PW'(active_power) * PW'(`PERCENT_FULL_SCALE);
  wire [PW-1:0] low_level    = PW'(rated_power) * PW'(cfg_r.low_percent);
  wire [PW-1:0] high_level   = PW'(rated_power) * PW'(cfg_r.high_percent);
  wire below_low  = power_scaled < low_level;   // see [RULE_05] [RULE_08]
  wire above_high = power_scaled > high_level;  // see [RULE_05] [RULE_08]

  wire both_zero    = (cfg_r.low_percent == '0) && (cfg_r.high_percent == '0);
  // Equal thresholds leave no band, so they count as inconsistent
  wire inconsistent = !(cfg_r.low_percent < cfg_r.high_percent);
  // see [RULE_12]
  wire cfg_ok       = !both_zero && !inconsistent;            // see [RULE_09]
  wire gate_open    = !cfg_r.enable_input_assigned
                      || threshold_enable_input;              // see [RULE_03]
  wire function_on  = cfg_ok && cfg_r.output_assigned
                      && gate_open;                           // see [RULE_04]

  // ************************************************************
  // Sequencing
  // ************************************************************
  monitor_state_e state_r;
  monitor_state_e state_nxt;
  logic           out_r;
  logic           out_nxt;
  logic           enable_prev_r;
  wire            enable_rise = threshold_enable_input && !enable_prev_r
                                && cfg_r.enable_input_assigned;

  wire settling = (state_r == ST_SETTLE);
  wire watching = (state_r == ST_WATCH) && function_on;

  // Set condition and clear condition swap with the mode
  wire set_cond = watching && (cfg_r.high_mode ? above_high
                                               : below_low); // see [RULE_01]
  wire clr_cond = watching && (cfg_r.high_mode ? below_low
                                               : above_high); // see [RULE_11]
  // The set side uses its mode's delay: low mode lower delay, high mode upper
  wire [15:0] set_delay = cfg_r.high_mode ? cfg_r.high_delay_s
                                          : cfg_r.low_delay_s;
  wire [15:0] clr_delay = cfg_r.high_mode ? cfg_r.low_delay_s
                                          : cfg_r.high_delay_s;
  logic set_done;
  logic clr_done;
  logic settle_done;

  qualify_timer #(.WIDTH(16)) set_timer (
    .clock     (clock),
    .reset     (reset),
    .sec_tick  (sec_tick),
    .condition (set_cond),
    .delay_s   (set_delay),
    .expired   (set_done)
  ); // see [RULE_06] [RULE_11] [RULE_13]

  qualify_timer #(.WIDTH(16)) clr_timer (
    .clock     (clock),
    .reset     (reset),
    .sec_tick  (sec_tick),
    .condition (clr_cond),
    .delay_s   (clr_delay),
    .expired   (clr_done)
  ); // see [RULE_07] [RULE_11] [RULE_13]

  qualify_timer #(.WIDTH(16)) settle_timer (
    .clock     (clock),
    .reset     (reset),
    .sec_tick  (sec_tick),
    .condition (settling && !enable_rise),
    .delay_s   (cfg_r.settle_s),
    .expired   (settle_done)
  ); // see [RULE_10]

  always_comb begin
    state_nxt = state_r;
    out_nxt   = out_r;
    case (state_r)
      ST_IDLE: begin
        out_nxt = 1'b0;
        if (function_on) begin
          state_nxt = cfg_r.enable_input_assigned ? ST_SETTLE : ST_WATCH;
        end
      end
      ST_SETTLE: begin
        out_nxt = 1'b0; // see [RULE_10]
        if (!function_on) begin
          state_nxt = ST_IDLE;
        end else if (settle_done) begin
          state_nxt = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (!function_on) begin
          state_nxt = ST_IDLE;
          out_nxt   = 1'b0;
        end else if (enable_rise) begin
          state_nxt = ST_SETTLE;
          out_nxt   = 1'b0;
        end else if (set_done) begin
          out_nxt = 1'b1; // see [RULE_06] [RULE_11]
        end else if (clr_done) begin
          out_nxt = 1'b0; // see [RULE_07] [RULE_11]
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        out_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r       <= ST_IDLE;
      out_r         <= 1'b0;
      enable_prev_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      out_r         <= out_nxt;
      enable_prev_r <= threshold_enable_input;
    end
  end

  assign load_threshold_output = out_r;
  assign monitor_active        = watching;

endmodule

// ===== testbench/ltm_props.sv
// Port-level assertions for the load threshold monitor
`timescale 1ns/100ps
module ltm_props
  import load_threshold_pkg::*;
#(
  parameter int POWER_WIDTH = 24
) (
  // Clock, reset and configuration
  input wire logic                   clock,
  input wire logic                   reset,
  input wire monitor_cfg_s           cfg,
  input wire logic                   cfg_valid,
  // Measurement, enable and result
  input wire logic [POWER_WIDTH-1:0] rated_power,
  input wire logic [POWER_WIDTH-1:0] active_power,
  input wire logic                   threshold_enable_input,
  input wire logic                   load_threshold_output,
  input wire logic                   monitor_active
);
  monitor_cfg_s c_r;
  wire [31:0] pw = 32'(active_power) * 32'h64;
  wire [31:0] lo = 32'(rated_power) * c_r.low_percent;
  wire [31:0] hi = 32'(rated_power) * c_r.high_percent;
  wire        set_c = c_r.high_mode ? (pw > hi) : (pw < lo);
  wire        clr_c = c_r.high_mode ? (pw < lo) : (pw > hi);
  wire        gate = !c_r.enable_input_assigned || threshold_enable_input;
  wire        ok = c_r.output_assigned && c_r.low_percent < c_r.high_percent
                   && gate;
  wire        off = !ok || !monitor_active || clr_c;
  wire        out = load_threshold_output;
  // Mirror of the captured configuration
  always_ff @(posedge clock) begin
    if (reset)
      c_r <= '0;
    else if (cfg_valid)
      c_r <= cfg;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> !out && !monitor_active) else $error("busy after reset");
  a_idle_off: assert property (!ok [*2] |=> !out)
    else $error("output high while disabled");
  a_active_ok: assert property (monitor_active |-> $past(ok))
    else $error("watching while gated");
  a_unassigned_idle: assert property (
    !c_r.output_assigned [*2] |=> !monitor_active) else $error("unassigned");
  a_settle_low: assert property ($rose(threshold_enable_input)
    && c_r.enable_input_assigned && c_r.settle_s > 16'h0001
    |=> ##1 !out [*4]) else $error("output during settle");
  a_set_cause: assert property (
    $rose(out) |-> $past(monitor_active && set_c)) else $error("bad set");
  a_clear_cause: assert property (
    $fell(out) |-> $past(off) || $past(off, 2)) else $error("bad clear");
  a_band_hold: assert property (
    (monitor_active && !set_c && !clr_c) [*3] |-> $stable(out))
    else $error("output moved inside band");
endmodule

bind load_threshold_monitor ltm_props #(.POWER_WIDTH(POWER_WIDTH)) i_props (
  .clock, .reset, .cfg, .cfg_valid, .rated_power, .active_power,
  .threshold_enable_input, .load_threshold_output, .monitor_active);

// ===== testbench/testbench.sv
// Self-checking bench for the load threshold monitor
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t got %h expected %h", $time, a, b); end end
module testbench import load_threshold_pkg::*;;
  // Short tick keeps the seconds counts cheap to simulate
  localparam int TICK = 10;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  monitor_cfg_s cfg = '0;
  logic         cfg_valid = 1'b0;
  logic [23:0]  rated = 24'h64;
  logic [23:0]  power = 24'h0;
  logic         enable = 1'b0;
  logic         out;
  logic         act;
  int           err_total = 0;
  int           checks = 0;
  load_threshold_monitor #(.TICK_CYCLES(TICK)) i_load_threshold_monitor (
    .clock, .reset, .cfg, .cfg_valid, .rated_power(rated),
    .active_power(power), .threshold_enable_input(enable),
    .load_threshold_output(out), .monitor_active(act));
  initial forever #5 clock = ~clock;
  task summarize;
    $display("Checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wait_out(input logic v, input int n);
    for (int i = 0; i < n && out !== v; i++) cyc(1);
    if (out !== v) begin
      err_total++;
      summarize();
    end
  endtask
  task set_cfg(input logic hm, input logic [6:0] lp, hp, input logic ea, oa);
    @(posedge clock);
    cfg <= '{hm, lp, 16'h0002, hp, 16'h0003, 16'h0002, ea, oa};
    cfg_valid <= 1'b1;
    @(posedge clock);
    cfg_valid <= 1'b0;
  endtask
  task drive(input logic [23:0] p);
    @(posedge clock);
    power <= p;
  endtask
  task t_reset;
    cyc(1);
    `CHK(out, 1'b0)
    cyc(60);
    `CHK(act, 1'b0)
  endtask
  task t_low;
    drive(24'h0A);
    set_cfg(1'b0, 7'h14, 7'h32, 1'b0, 1'b1);
    cyc(3);
    `CHK(act, 1'b1)
    `CHK(out, 1'b0)
    wait_out(1'b1, 40);
    `CHK(out, 1'b1)
    drive(24'h3C);
    cyc(15);
    drive(24'h1E);
    cyc(40);
    `CHK(out, 1'b1)
    drive(24'h3C);
    cyc(15);
    `CHK(out, 1'b1)
    wait_out(1'b0, 40);
    `CHK(out, 1'b0)
  endtask
  task t_high;
    @(posedge clock);
    rated <= 24'hC8;
    power <= 24'h5A;
    set_cfg(1'b1, 7'h14, 7'h32, 1'b0, 1'b1);
    cyc(40);
    `CHK(out, 1'b0)
    drive(24'h6E);
    wait_out(1'b1, 50);
    `CHK(out, 1'b1)
    drive(24'h1E);
    wait_out(1'b0, 40);
    `CHK(out, 1'b0)
  endtask
  task t_refuse;
    logic [6:0] lp [3] = '{7'h1E, 7'h28, 7'h14};
    logic [6:0] hp [3] = '{7'h1E, 7'h14, 7'h32};
    drive(24'h0A);
    for (int i = 0; i < 3; i++) begin
      set_cfg(1'b0, lp[i], hp[i], 1'b0, i != 2);
      cyc(60);
      `CHK(out, 1'b0)
      `CHK(act, 1'b0)
    end
  endtask
  task t_enable;
    set_cfg(1'b0, 7'h14, 7'h32, 1'b1, 1'b1);
    cyc(60);
    `CHK(out, 1'b0)
    @(posedge clock);
    enable <= 1'b1;
    cyc(8);
    `CHK(out, 1'b0)
    wait_out(1'b1, 60);
    `CHK(out, 1'b1)
    @(posedge clock);
    enable <= 1'b0;
    cyc(3);
    `CHK(out, 1'b0)
  endtask
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_low();
    t_high();
    t_refuse();
    t_enable();
    summarize();
  end
endmodule
